// ===== cfe_charger_fault_flags.sv
`timescale 1ns/1ps
// ============================================================
module cfe_charger_fault_flags
(
	// System clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Host register port
	input wire logic clk_link,
	input wire logic host_req,
	input wire logic host_write,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic host_busy,
	output logic host_done,
	output logic [7:0] host_rdata,
	// Charger condition inputs
	input wire logic power_good,
	input wire logic input_current_limit_active,
	input wire logic input_voltage_limit_active,
	input wire logic thermal_regulation_active,
	input wire logic timeout_expired_status,
	input wire logic termination_detect,
	input wire logic [2:0] charge_state,
	input wire logic input_overvoltage_detect,
	input wire logic thermal_shutdown_detect,
	input wire logic battery_overvoltage_detect,
	input wire logic flying_capacitor_detect,
	input wire logic capacitor_precondition_failed,
	input wire logic safety_timer_expired,
	input wire logic weak_source_trial_done,
	input wire logic weak_source_trial_failed,
	// Charger control outputs
	output logic alert_pulse,
	output logic timeout_kick,
	output logic [1:0] timeout_select,
	output logic register_preset
);

	cfe_xfer_if xfer();

	cfe_pkg::cfe_pins_type pins_raw;
	cfe_pkg::cfe_pins_type pins_meta;
	cfe_pkg::cfe_pins_type pins_sync;

	logic req_meta;
	logic req_sync;
	logic req_seen;
	logic take;
	logic take_read;
	logic take_write;

	logic [7:0] fault_condition_status;
	logic [7:0] next_fault_status;
	logic [7:0] event_flag_latch;
	logic [7:0] fault_flag_latch;
	logic [7:0] event_alert_mask;
	logic [7:0] fault_alert_mask;
	logic [7:0] event_fresh;
	logic [7:0] fault_fresh;
	logic [7:0] event_cond;
	logic [7:0] fault_cond;
	logic [7:0] read_value;

	logic wd_prev;
	logic wd_hold;
	logic [2:0] chg_prev;
	logic chg_toggle;
	logic weak_done_prev;
	logic [2:0] weak_fail_count;
	logic weak_status;
	logic [7:0] alert_count;
	logic clear_event;
	logic clear_fault;
	logic preset_now;
	logic kick_now;
	logic sel_change;

	// ============================================================
	// Link side port
	cfe_link_port u_link
	(
		.clk_link(clk_link),
		.reset(reset),
		.host_req(host_req),
		.host_write(host_write),
		.host_addr(host_addr),
		.host_wdata(host_wdata),
		.host_busy(host_busy),
		.host_done(host_done),
		.host_rdata(host_rdata),
		.xfer(xfer.link)
	);

	// ============================================================
	// Input synchronisers
	assign pins_raw = '{
		power_good: power_good,
		icl_active: input_current_limit_active,
		ivl_active: input_voltage_limit_active,
		treg_active: thermal_regulation_active,
		wd_expired: timeout_expired_status,
		term_detect: termination_detect,
		charge_state: charge_state,
		ovp_detect: input_overvoltage_detect,
		tshut_detect: thermal_shutdown_detect,
		batovp_detect: battery_overvoltage_detect,
		cfly_detect: flying_capacitor_detect,
		capcond_failed: capacitor_precondition_failed,
		timer_expired: safety_timer_expired,
		weak_trial_done: weak_source_trial_done,
		weak_trial_failed: weak_source_trial_failed
	};

	always_ff @(posedge clk_sys)
	begin
		pins_meta <= pins_raw;
		pins_sync <= pins_meta;
		req_meta <= xfer.req_toggle;
		req_sync <= req_meta;
	end

	// ============================================================
	// Request decode
	assign take = req_sync != req_seen;
	assign take_read = take && !xfer.req_write;
	assign take_write = take && xfer.req_write;
	assign clear_event = take_read
		&& xfer.req_addr == cfe_pkg::CFE_OFF_EVENT_FLAG;
	assign clear_fault = take_read
		&& xfer.req_addr == cfe_pkg::CFE_OFF_FAULT_FLAG;
	assign preset_now = take_write
		&& xfer.req_addr == cfe_pkg::CFE_OFF_PART_INFO
		&& xfer.req_wdata[cfe_pkg::CFE_BIT_PRESET];
	assign kick_now = take_write
		&& xfer.req_addr == cfe_pkg::CFE_OFF_TIMER_CTRL
		&& xfer.req_wdata[cfe_pkg::CFE_BIT_KICK];
	assign sel_change = take_write
		&& xfer.req_addr == cfe_pkg::CFE_OFF_TIMER_CTRL
		&& xfer.req_wdata[cfe_pkg::CFE_SEL_MSB:cfe_pkg::CFE_SEL_LSB]
		!= timeout_select;

	// ============================================================
	// Timeout hold of the protection status bits
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wd_prev <= 1'b0;
			wd_hold <= 1'b0;
		end
		else
		begin
			wd_prev <= pins_sync.wd_expired;
			if (pins_sync.wd_expired && !wd_prev)
				wd_hold <= 1'b1;
			else if (kick_now || sel_change || preset_now)
				wd_hold <= 1'b0;
		end
	end

	// ============================================================
	// Weak source failure counter
	always_ff @(posedge clk_sys)
	begin
		if (reset || preset_now)
		begin
			weak_done_prev <= 1'b0;
			weak_fail_count <= 3'h0;
		end
		else
		begin
			weak_done_prev <= pins_sync.weak_trial_done;
			if (pins_sync.weak_trial_done && !weak_done_prev)
			begin
				if (!pins_sync.weak_trial_failed)
					weak_fail_count <= 3'h0;
				else if (weak_fail_count != cfe_pkg::CFE_WEAK_FAIL_LIMIT)
					weak_fail_count <= weak_fail_count + 3'h1;
			end
		end
	end

	assign weak_status = weak_fail_count == cfe_pkg::CFE_WEAK_FAIL_LIMIT;

	// ============================================================
	// Fault status register
	always_comb
	begin
		next_fault_status = cfe_pkg::CFE_STATUS_RESET;
		next_fault_status[cfe_pkg::CFE_FS_OVP] =
			pins_sync.ovp_detect && !wd_hold;
		next_fault_status[cfe_pkg::CFE_FS_TSHUT] =
			pins_sync.tshut_detect && !wd_hold;
		next_fault_status[cfe_pkg::CFE_FS_BATOVP] =
			pins_sync.batovp_detect && !wd_hold;
		next_fault_status[cfe_pkg::CFE_FS_CFLY] =
			pins_sync.cfly_detect && !wd_hold;
		next_fault_status[cfe_pkg::CFE_FS_CAPCOND] =
			pins_sync.capcond_failed;
		next_fault_status[cfe_pkg::CFE_FS_WEAK] = weak_status;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset || preset_now)
			fault_condition_status <= cfe_pkg::CFE_STATUS_RESET;
		else
			fault_condition_status <= next_fault_status;
	end

	// ============================================================
	// Charge state change detector
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			chg_prev <= 3'h0;
			chg_toggle <= 1'b0;
		end
		else
		begin
			chg_prev <= pins_sync.charge_state;
			if (pins_sync.charge_state != chg_prev)
				chg_toggle <= ~chg_toggle;
		end
	end

	// ============================================================
	// Event and fault flag banks
	always_comb
	begin
		event_cond = cfe_pkg::CFE_FLAG_RESET;
		event_cond[cfe_pkg::CFE_EV_PG] = pins_sync.power_good;
		event_cond[cfe_pkg::CFE_EV_ICL] = pins_sync.icl_active;
		event_cond[cfe_pkg::CFE_EV_IVL] = pins_sync.ivl_active;
		event_cond[cfe_pkg::CFE_EV_TREG] = pins_sync.treg_active;
		event_cond[cfe_pkg::CFE_EV_WD] = pins_sync.wd_expired;
		event_cond[cfe_pkg::CFE_EV_TERM] = pins_sync.term_detect;
		event_cond[cfe_pkg::CFE_EV_CHG] = chg_toggle;
	end

	always_comb
	begin
		fault_cond = next_fault_status;
		fault_cond[cfe_pkg::CFE_FF_TIMER] = pins_sync.timer_expired;
	end

	cfe_flag_bank
	#(
		.VALID_BITS(cfe_pkg::CFE_EVENT_VALID),
		.BOTH_EDGES(cfe_pkg::CFE_EVENT_BOTH_EDGES)
	)
	u_event_bank
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.preset(preset_now),
		.clear_read(clear_event),
		.cond(event_cond),
		.flags(event_flag_latch),
		.fresh(event_fresh)
	);

	cfe_flag_bank
	#(
		.VALID_BITS(cfe_pkg::CFE_FAULT_VALID),
		.BOTH_EDGES(cfe_pkg::CFE_FAULT_BOTH_EDGES)
	)
	u_fault_bank
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.preset(preset_now),
		.clear_read(clear_fault),
		.cond(fault_cond),
		.flags(fault_flag_latch),
		.fresh(fault_fresh)
	);

	// ============================================================
	// Writable registers
	always_ff @(posedge clk_sys)
	begin
		if (reset || preset_now)
		begin
			event_alert_mask <= cfe_pkg::CFE_MASK_RESET;
			fault_alert_mask <= cfe_pkg::CFE_MASK_RESET;
			timeout_select <= cfe_pkg::CFE_SEL_RESET;
		end
		else if (take_write)
		begin
			unique case (xfer.req_addr)
				cfe_pkg::CFE_OFF_EVENT_MASK:
					event_alert_mask <= xfer.req_wdata
						& cfe_pkg::CFE_EVENT_VALID;
				cfe_pkg::CFE_OFF_FAULT_MASK:
					fault_alert_mask <= xfer.req_wdata
						& cfe_pkg::CFE_FAULT_VALID;
				cfe_pkg::CFE_OFF_TIMER_CTRL:
					timeout_select <= xfer.req_wdata[
						cfe_pkg::CFE_SEL_MSB:cfe_pkg::CFE_SEL_LSB];
				default:
					timeout_select <= timeout_select;
			endcase
		end
	end

	// ============================================================
	// Self-clearing command pulses
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			timeout_kick <= 1'b0;
			register_preset <= 1'b0;
		end
		else
		begin
			timeout_kick <= kick_now;
			register_preset <= preset_now;
		end
	end

	// ============================================================
	// Read multiplexer and answer
	always_comb
	begin
		read_value = 8'h00;
		unique case (xfer.req_addr)
			cfe_pkg::CFE_OFF_FAULT_STATUS:
				read_value = fault_condition_status;
			cfe_pkg::CFE_OFF_EVENT_FLAG:
				read_value = event_flag_latch;
			cfe_pkg::CFE_OFF_FAULT_FLAG:
				read_value = fault_flag_latch;
			cfe_pkg::CFE_OFF_EVENT_MASK:
				read_value = event_alert_mask;
			cfe_pkg::CFE_OFF_FAULT_MASK:
				read_value = fault_alert_mask;
			cfe_pkg::CFE_OFF_TIMER_CTRL:
				read_value[cfe_pkg::CFE_SEL_MSB:cfe_pkg::CFE_SEL_LSB] =
					timeout_select;
			default:
				read_value = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			req_seen <= 1'b0;
			xfer.ack_toggle <= 1'b0;
			xfer.ack_rdata <= 8'h00;
		end
		else if (take)
		begin
			req_seen <= req_sync;
			xfer.ack_toggle <= ~xfer.ack_toggle;
			xfer.ack_rdata <= xfer.req_write ? 8'h00 : read_value;
		end
	end

	// ============================================================
	// Alert pulse generator
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			alert_count <= 8'h00;
			alert_pulse <= 1'b0;
		end
		else if (|(event_fresh & ~event_alert_mask)
			|| |(fault_fresh & ~fault_alert_mask))
		begin
			alert_count <= cfe_pkg::CFE_ALERT_PULSE_COUNT - 8'h01;
			alert_pulse <= 1'b1;
		end
		else if (alert_count != 8'h00)
		begin
			alert_count <= alert_count - 8'h01;
			alert_pulse <= 1'b1;
		end
		else
			alert_pulse <= 1'b0;
	end

endmodule

// ===== cfe_charger_fault_flags_props.sv
`timescale 1ns/1ps
// ============================================================
// Port checker
module cfe_charger_fault_flags_props
(
	// Clocks and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_link,
	// Host port
	input wire logic host_req,
	input wire logic host_busy,
	input wire logic host_done,
	input wire logic [7:0] host_rdata,
	// Control outputs
	input wire logic alert_pulse,
	input wire logic timeout_kick,
	input wire logic [1:0] timeout_select,
	input wire logic register_preset
);
	logic [7:0] alert_cnt;

	// ============================================================
	// Alert length counter
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			alert_cnt <= 8'h00;
		else if (alert_pulse)
			alert_cnt <= alert_cnt + 8'h01;
		else
			alert_cnt <= 8'h00;
	end

	// ============================================================
	// Sequences
	sequence taken_s;
		host_req && !host_busy;
	endsequence
	sequence answer_s;
		(!host_done) [*3] ##[1:4] host_done;
	endsequence

	// ============================================================
	// Assertions
	answer_time_a: assert property (@(posedge clk_link) disable iff (reset)
		taken_s |=> answer_s) else $error("answer out of window");
	done_pulse_a: assert property (@(posedge clk_link) disable iff (reset)
		host_done |=> !host_done) else $error("done longer than one cycle");
	busy_end_a: assert property (@(posedge clk_link) disable iff (reset)
		$fell(host_busy) |-> host_done) else $error("busy ended without done");
	rdata_hold_a: assert property (@(posedge clk_link) disable iff (reset)
		!host_done |-> $stable(host_rdata)) else $error("read data moved");
	kick_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
		timeout_kick |=> !timeout_kick) else $error("kick too long");
	preset_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
		register_preset |=> !register_preset) else $error("preset too long");
	preset_select_a: assert property (@(posedge clk_sys) disable iff (reset)
		register_preset |-> ##[0:2] timeout_select == 2'h1)
		else $error("select not restored");
	alert_length_a: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(alert_pulse) |-> alert_cnt >= cfe_pkg::CFE_ALERT_PULSE_COUNT)
		else $error("alert pulse too short");
endmodule

bind cfe_charger_fault_flags cfe_charger_fault_flags_props chk
(
	.clk_sys(clk_sys),
	.reset(reset),
	.clk_link(clk_link),
	.host_req(host_req),
	.host_busy(host_busy),
	.host_done(host_done),
	.host_rdata(host_rdata),
	.alert_pulse(alert_pulse),
	.timeout_kick(timeout_kick),
	.timeout_select(timeout_select),
	.register_preset(register_preset)
);

// ===== cfe_charger_fault_flags_tb.sv
`timescale 1ns/1ps
// ============================================================
// Testbench
module cfe_charger_fault_flags_tb;
	logic clk_sys, clk_link, reset, wdone, wfail;
	logic [7:0] ev, flt, m;
	logic [2:0] cs;
	logic req, wr_n, busy, done, alert, kick, pre;
	logic [7:0] addr, wdat, rdat;
	logic [1:0] sel;
	int fails, total_checks, cyc, i;

	cfe_charger_fault_flags uut
	(
		.clk_sys(clk_sys), .reset(reset), .clk_link(clk_link),
		.host_req(req), .host_write(wr_n), .host_addr(addr),
		.host_wdata(wdat), .host_busy(busy), .host_done(done),
		.host_rdata(rdat), .power_good(ev[7]),
		.input_current_limit_active(ev[6]),
		.input_voltage_limit_active(ev[5]),
		.thermal_regulation_active(ev[4]),
		.timeout_expired_status(ev[3]), .termination_detect(ev[2]),
		.charge_state(cs), .input_overvoltage_detect(flt[7]),
		.thermal_shutdown_detect(flt[6]),
		.battery_overvoltage_detect(flt[5]),
		.flying_capacitor_detect(flt[4]),
		.capacitor_precondition_failed(flt[2]),
		.safety_timer_expired(flt[3]), .weak_source_trial_done(wdone),
		.weak_source_trial_failed(wfail), .alert_pulse(alert),
		.timeout_kick(kick), .timeout_select(sel), .register_preset(pre)
	);
	cfe_host_model hm
	(
		.clk_link(clk_link), .host_req(req), .host_write(wr_n),
		.host_addr(addr), .host_wdata(wdat), .host_busy(busy),
		.host_done(done), .host_rdata(rdat)
	);

	// ============================================================
	// Clocks and hang guard
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial
	begin
		clk_link = 1'b0;
		#7;
		forever #40 clk_link = ~clk_link;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			report_and_stop();
		end
	end

	// ============================================================
	// Helpers
	function automatic logic [7:0] bitv(input int n);
		return 8'h01 << n;
	endfunction
	function automatic logic [7:0] stat(input logic [7:0] f, input logic h);
		return h ? (f & 8'h04) : (f & 8'hf4);
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		hm.access(1'b0, a, 8'h00, d);
		chk(d, exp);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		hm.access(1'b1, a, d, r);
	endtask
	task automatic trial();
		wdone = 1'b1;
		tick(8);
		wdone = 1'b0;
		tick(8);
	endtask
	task automatic watch(input int n, output logic seen);
		seen = 1'b0;
		repeat (n)
		begin
			@(posedge clk_sys);
			#1;
			if (alert === 1'b1)
				seen = 1'b1;
		end
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ============================================================
	// Main sequence
	initial
	begin
		{ev, flt, cs, wdone, wfail} = '0;
		reset = 1'b1;
		void'($urandom(58));
		repeat (16) @(posedge clk_link);
		@(posedge clk_sys);
		#1;
		chk({alert, kick, pre, 3'h0, sel}, 8'h01);
		reset = 1'b0;
		tick(100);
		rchk(cfe_pkg::CFE_OFF_EVENT_FLAG, 8'h00);
		rchk(cfe_pkg::CFE_OFF_FAULT_FLAG, 8'h00);
		rchk(cfe_pkg::CFE_OFF_EVENT_MASK, 8'h00);
		for (i = 2; i < 8; i++)
		begin
			ev[i] = 1'b1;
			tick(10);
			rchk(cfe_pkg::CFE_OFF_EVENT_FLAG, bitv(i));
			rchk(cfe_pkg::CFE_OFF_EVENT_FLAG, 8'h00);
			ev[i] = 1'b0;
			tick(10);
			rchk(cfe_pkg::CFE_OFF_EVENT_FLAG, (i == 7) ? bitv(7) : 8'h00);
		end
		repeat (4)
		begin
			cs = cs + 3'($urandom_range(1, 7));
			tick(10);
			rchk(cfe_pkg::CFE_OFF_EVENT_FLAG, 8'h01);
		end
		flt = 8'hfc;
		tick(10);
		rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, stat(flt, 1'b1));
		rchk(cfe_pkg::CFE_OFF_FAULT_FLAG, 8'h0c);
		wreg(cfe_pkg::CFE_OFF_TIMER_CTRL, 8'h50);
		tick(10);
		rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, stat(flt, 1'b0));
		rchk(cfe_pkg::CFE_OFF_FAULT_FLAG, 8'hf0);
		rchk(cfe_pkg::CFE_OFF_FAULT_FLAG, 8'h00);
		flt = 8'h00;
		tick(10);
		rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, 8'h00);
		repeat (6)
		begin
			i = $urandom_range(2, 7);
			flt = bitv(i);
			tick(10);
			rchk(cfe_pkg::CFE_OFF_FAULT_FLAG, bitv(i));
			rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, stat(flt, 1'b0));
			flt = 8'h00;
			tick(10);
		end
		ev[3] = 1'b1;
		flt = 8'h80;
		tick(10);
		rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, 8'h00);
		wreg(cfe_pkg::CFE_OFF_TIMER_CTRL, 8'h20);
		tick(10);
		rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, 8'h80);
		{ev, flt} = '0;
		wfail = 1'b1;
		repeat (6) trial();
		rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, 8'h00);
		trial();
		rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, 8'h02);
		rchk(cfe_pkg::CFE_OFF_FAULT_FLAG, 8'h82);
		wfail = 1'b0;
		trial();
		rchk(cfe_pkg::CFE_OFF_FAULT_STATUS, 8'h00);
		wreg(cfe_pkg::CFE_OFF_EVENT_MASK, 8'hff);
		rchk(cfe_pkg::CFE_OFF_EVENT_MASK, 8'hfd);
		rchk(cfe_pkg::CFE_OFF_EVENT_FLAG, 8'h08);
		tick(80);
		ev[6] = 1'b1;
		watch(30, m[0]);
		chk({7'h00, m[0]}, 8'h00);
		ev[6] = 1'b0;
		wreg(cfe_pkg::CFE_OFF_EVENT_MASK, 8'h00);
		ev[6] = 1'b1;
		watch(30, m[0]);
		chk({7'h00, m[0]}, 8'h01);
		m = 8'($urandom);
		wreg(cfe_pkg::CFE_OFF_FAULT_MASK, m);
		rchk(cfe_pkg::CFE_OFF_FAULT_MASK, m & 8'hfe);
		wreg(cfe_pkg::CFE_OFF_EVENT_MASK, m);
		wreg(cfe_pkg::CFE_OFF_PART_INFO, 8'h80);
		rchk(cfe_pkg::CFE_OFF_EVENT_FLAG, 8'h00);
		rchk(cfe_pkg::CFE_OFF_EVENT_MASK, 8'h00);
		rchk(cfe_pkg::CFE_OFF_FAULT_MASK, 8'h00);
		rchk(cfe_pkg::CFE_OFF_TIMER_CTRL, 8'h10);
		rchk(cfe_pkg::CFE_OFF_PART_INFO, 8'h00);
		rchk(8'h20, 8'h00);
		report_and_stop();
	end
endmodule

// ===== cfe_flag_bank.sv
`timescale 1ns/1ps
// ============================================================
// Edge-latched flag register with clear on read
module cfe_flag_bank
#(
	parameter logic [7:0] VALID_BITS = 8'hff,
	parameter logic [7:0] BOTH_EDGES = 8'h00
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control
	input wire logic preset,
	input wire logic clear_read,
	// Conditions and results
	input wire logic [7:0] cond,
	output logic [7:0] flags,
	output logic [7:0] fresh
);

	logic [7:0] prev;
	logic [7:0] edges;

	// ============================================================
	// Edge detection
	assign edges = ((cond & ~prev) | (BOTH_EDGES & (cond ^ prev)))
		& VALID_BITS;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			prev <= cfe_pkg::CFE_FLAG_RESET;
		else
			prev <= cond;
	end

	// ============================================================
	// Flag latch, a new edge wins over the clearing read
	always_ff @(posedge clk_sys)
	begin
		if (reset || preset)
			flags <= cfe_pkg::CFE_FLAG_RESET;
		else if (clear_read)
			flags <= edges;
		else
			flags <= flags | edges;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset || preset)
			fresh <= cfe_pkg::CFE_FLAG_RESET;
		else
			fresh <= edges;
	end

endmodule

// ===== cfe_host_model.sv
`timescale 1ns/1ps
// ============================================================
// Host register master on the link clock
module cfe_host_model
(
	// Link clock
	input wire logic clk_link,
	// Request side
	output logic host_req,
	output logic host_write,
	output logic [7:0] host_addr,
	output logic [7:0] host_wdata,
	// Answer side
	input wire logic host_busy,
	input wire logic host_done,
	input wire logic [7:0] host_rdata
);
	initial
	begin
		host_req = 1'b0;
		host_write = 1'b0;
		host_addr = 8'hff;
		host_wdata = 8'h00;
	end

	// ============================================================
	// One register access, unknown data on no answer
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_link);
		#1;
		host_req = 1'b1;
		host_write = wr;
		host_addr = a;
		host_wdata = wd;
		@(posedge clk_link);
		#1;
		host_req = 1'b0;
		while (host_done !== 1'b1 && n < 12)
		begin
			@(posedge clk_link);
			#1;
			n++;
		end
		rd = (host_done === 1'b1) ? host_rdata : 8'hxx;
		host_addr = ~a;
		host_wdata = ~wd;
	endtask
endmodule

// ===== cfe_link_port.sv
`timescale 1ns/1ps
// ============================================================
// Host register port on the link clock
module cfe_link_port
(
	// Link clock and system reset
	input wire logic clk_link,
	input wire logic reset,
	// Host request side
	input wire logic host_req,
	input wire logic host_write,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic host_busy,
	output logic host_done,
	output logic [7:0] host_rdata,
	// Crossing to the core
	cfe_xfer_if.link xfer
);

	logic rst_meta;
	logic rst_link;
	logic ack_meta;
	logic ack_sync;
	logic ack_seen;
	cfe_pkg::cfe_link_state_type state;

	// ============================================================
	// Reset and acknowledge synchronisers
	always_ff @(posedge clk_link)
	begin
		rst_meta <= reset;
		rst_link <= rst_meta;
		ack_meta <= xfer.ack_toggle;
		ack_sync <= ack_meta;
	end

	// ============================================================
	// Request and answer sequencing
	always_ff @(posedge clk_link)
	begin
		if (rst_link)
		begin
			state <= cfe_pkg::CFE_LINK_IDLE;
			xfer.req_toggle <= 1'b0;
			xfer.req_write <= 1'b0;
			xfer.req_addr <= 8'h00;
			xfer.req_wdata <= 8'h00;
			ack_seen <= 1'b0;
			host_busy <= 1'b0;
			host_done <= 1'b0;
			host_rdata <= 8'h00;
		end
		else
		begin
			host_done <= 1'b0;
			unique case (state)
				cfe_pkg::CFE_LINK_IDLE:
				begin
					if (host_req)
					begin
						xfer.req_write <= host_write;
						xfer.req_addr <= host_addr;
						xfer.req_wdata <= host_wdata;
						xfer.req_toggle <= ~xfer.req_toggle;
						host_busy <= 1'b1;
						state <= cfe_pkg::CFE_LINK_WAIT;
					end
				end
				cfe_pkg::CFE_LINK_WAIT:
				begin
					if (ack_sync != ack_seen)
					begin
						ack_seen <= ack_sync;
						host_rdata <= xfer.ack_rdata;
						host_done <= 1'b1;
						host_busy <= 1'b0;
						state <= cfe_pkg::CFE_LINK_IDLE;
					end
				end
				default:
					state <= cfe_pkg::CFE_LINK_IDLE;
			endcase
		end
	end

endmodule

// ===== cfe_pkg.sv
// ============================================================
// Shared constants and types
package cfe_pkg;

	// ============================================================
	// Register offsets
	localparam logic [7:0] CFE_OFF_TIMER_CTRL = 8'h05;
	localparam logic [7:0] CFE_OFF_FAULT_STATUS = 8'h08;
	localparam logic [7:0] CFE_OFF_EVENT_FLAG = 8'h09;
	localparam logic [7:0] CFE_OFF_FAULT_FLAG = 8'h0a;
	localparam logic [7:0] CFE_OFF_EVENT_MASK = 8'h0b;
	localparam logic [7:0] CFE_OFF_FAULT_MASK = 8'h0c;
	localparam logic [7:0] CFE_OFF_PART_INFO = 8'h0d;

	// ============================================================
	// Field positions
	localparam int CFE_BIT_KICK = 6;
	localparam int CFE_SEL_LSB = 4;
	localparam int CFE_SEL_MSB = 5;
	localparam int CFE_BIT_PRESET = 7;
	localparam int CFE_FS_OVP = 7;
	localparam int CFE_FS_TSHUT = 6;
	localparam int CFE_FS_BATOVP = 5;
	localparam int CFE_FS_CFLY = 4;
	localparam int CFE_FS_CAPCOND = 2;
	localparam int CFE_FS_WEAK = 1;
	localparam int CFE_FF_TIMER = 3;
	localparam int CFE_EV_PG = 7;
	localparam int CFE_EV_ICL = 6;
	localparam int CFE_EV_IVL = 5;
	localparam int CFE_EV_TREG = 4;
	localparam int CFE_EV_WD = 3;
	localparam int CFE_EV_TERM = 2;
	localparam int CFE_EV_CHG = 0;

	// ============================================================
	// Implemented bits and edge kinds
	localparam logic [7:0] CFE_EVENT_VALID = 8'hfd;
	localparam logic [7:0] CFE_FAULT_VALID = 8'hfe;
	localparam logic [7:0] CFE_EVENT_BOTH_EDGES = 8'h81;
	localparam logic [7:0] CFE_FAULT_BOTH_EDGES = 8'h00;

	// ============================================================
	// Reset values and weak failure limit
	localparam logic [7:0] CFE_MASK_RESET = 8'h00;
	localparam logic [7:0] CFE_FLAG_RESET = 8'h00;
	localparam logic [7:0] CFE_STATUS_RESET = 8'h00;
	localparam logic [1:0] CFE_SEL_RESET = 2'h1;
	localparam logic [2:0] CFE_WEAK_FAIL_LIMIT = 3'h7;

	// ============================================================
	// Timing
	localparam int CFE_SYS_PERIOD_PS = 5000;
	localparam int CFE_ALERT_PULSE_NS = 256;
	localparam int CFE_ALERT_PULSE_CYCLES =
		(CFE_ALERT_PULSE_NS * 1000 + CFE_SYS_PERIOD_PS - 1) /
		CFE_SYS_PERIOD_PS;
	localparam logic [7:0] CFE_ALERT_PULSE_COUNT =
		8'(CFE_ALERT_PULSE_CYCLES);

	// ============================================================
	// Types
	typedef struct packed {
		logic power_good;
		logic icl_active;
		logic ivl_active;
		logic treg_active;
		logic wd_expired;
		logic term_detect;
		logic [2:0] charge_state;
		logic ovp_detect;
		logic tshut_detect;
		logic batovp_detect;
		logic cfly_detect;
		logic capcond_failed;
		logic timer_expired;
		logic weak_trial_done;
		logic weak_trial_failed;
	} cfe_pins_type;

	typedef enum logic [1:0] {
		CFE_LINK_IDLE = 2'b01,
		CFE_LINK_WAIT = 2'b10
	} cfe_link_state_type;

endpackage

// ===== cfe_xfer_if.sv
`timescale 1ns/1ps
// ============================================================
// Register request crossing between link and system domains
interface cfe_xfer_if;
	logic req_toggle;
	logic req_write;
	logic [7:0] req_addr;
	logic [7:0] req_wdata;
	logic ack_toggle;
	logic [7:0] ack_rdata;

	modport link
	(
		output req_toggle,
		output req_write,
		output req_addr,
		output req_wdata,
		input ack_toggle,
		input ack_rdata
	);

	modport core
	(
		input req_toggle,
		input req_write,
		input req_addr,
		input req_wdata,
		output ack_toggle,
		output ack_rdata
	);
endinterface
